// >>> core/bpp_regs.svh
// What this block does
// R01 - store each incoming configuration payload in an internal buffer; the code drops a payload that finds no matching or free slot
// R02 - upstream delivers each payload before its emission time
// R03 - set up processing stages from buffered content before the next frame
// R04 - release payload to inserter when timing manager says, right after bootstrap
// R05 - strip length field and check word from emitted stream, use for error check
// R06 - split payload into per-stage instructions, deliver at timing manager's time
// R07 - hold payload in buffer during reconfiguration until its frame is emitted
// R08 - tag each copy with its frame's bootstrap emission time
// R09 - optionally combine redundant copies by majority vote
// R10 - timing manager supplies copy count per frame
// R11 - buffer indexed by emission time, entry freed after release
`ifndef BPP_REGS_SVH
`define BPP_REGS_SVH
`define BPP_LEN_BYTES 2
`define BPP_CHK_BYTES 2
`define BPP_CHK_INIT 16'hFFFF
`define BPP_CHK_POLY 16'h1021
`define BPP_INSTR_BYTES 4
`endif

// >>> core/bpp_pkg.sv
package bpp_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_LEN,
    ST_BODY,
    ST_CHK,
    ST_DONE
  } bpp_rx_state_t;
  typedef enum logic [1:0] {
    TX_IDLE,
    TX_SEND,
    TX_CFG
  } bpp_tx_state_t;
endpackage : bpp_pkg

// >>> core/bpp_vote.sv
`timescale 1ns/1ps
// bitwise majority of three byte copies; fewer copies fall back
module bpp_vote (
  // copies
  input wire logic [7:0] copy_a,
  input wire logic [7:0] copy_b,
  input wire logic [7:0] copy_c,
  input wire logic [1:0] n_copies,
  // result
  output logic [7:0] voted
);
  wire [7:0] maj = (copy_a & copy_b) | (copy_a & copy_c) | (copy_b & copy_c);
  assign voted = (n_copies >= 2'h3) ? maj : copy_a;
endmodule : bpp_vote

// >>> core/bpp_parser.sv
`timescale 1ns/1ps
`include "bpp_regs.svh"
module bpp_parser #(
  parameter int SLOTS = 4,
  parameter int DEPTH = 64,
  parameter int TW = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // payload from link_stream_demultiplexer
  input wire logic in_valid,
  input wire logic [7:0] in_data,
  input wire logic in_first,
  input wire logic in_last,
  input wire logic [TW-1:0] in_time,
  output logic in_ready,
  // timing manager
  input wire logic [1:0] copy_count,
  input wire logic cfg_go,
  input wire logic [TW-1:0] cfg_time,
  input wire logic release_go,
  input wire logic [TW-1:0] release_time,
  // inserter stream
  output logic out_valid,
  output logic [7:0] out_data,
  output logic out_last,
  // stage instructions
  output logic instr_valid,
  output logic [7:0] instr_stage,
  output logic [31:0] instr_word,
  // status
  output logic chk_err,
  output logic rel_miss
);
  localparam int AW = $clog2(DEPTH);
  localparam int SW = $clog2(SLOTS);

  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {b, 8'h00};
    for (int i = 0; i < 8; i++) begin
      r = r[15] ? ((r << 1) ^ `BPP_CHK_POLY) : (r << 1);
    end
    return r;
  endfunction : crc_byte

  // per slot storage: up to three copies
  logic [7:0] mem_q [SLOTS][3][DEPTH];
  logic [TW-1:0] tag_q [SLOTS];
  logic [SLOTS-1:0] used_q, good_q;
  logic [1:0] ncp_q [SLOTS];
  logic [AW:0] blen_q [SLOTS];

  bpp_pkg::bpp_rx_state_t rx_q;
  logic [SW-1:0] ws_q;
  logic [1:0] wc_q;
  logic [15:0] len_q, crc_q, rchk_q;
  logic [AW:0] wp_q;
  logic [1:0] hb_q;
  logic [15:0] cnt_q;

  // slot lookup by emission time
  logic hit;
  logic [SW-1:0] hit_idx, free_idx;
  logic free_ok;
  always_comb begin
    hit = 1'b0;
    hit_idx = '0;
    free_ok = 1'b0;
    free_idx = '0;
    for (int i = SLOTS - 1; i >= 0; i--) begin
      if (used_q[i] && tag_q[i] == in_time) begin // R08
        hit = 1'b1;
        hit_idx = SW'(i);
      end
      if (!used_q[i]) begin
        free_ok = 1'b1;
        free_idx = SW'(i);
      end
    end
  end

  wire rx_take = in_valid && in_ready;
  wire [15:0] crc_n = crc_byte(crc_q, in_data);
  wire [15:0] crc_first = crc_byte(`BPP_CHK_INIT, in_data);
  wire [15:0] chk_word = {rchk_q[7:0], in_data};

  // refuse for one cycle after the first byte of a payload that finds no slot
  wire refuse = (rx_q == bpp_pkg::ST_IDLE) && rx_take && in_first && !hit && !free_ok;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      in_ready <= 1'b0;
    end else begin
      in_ready <= !refuse;
    end
  end

  // tx side
  bpp_pkg::bpp_tx_state_t tx_q;
  logic [SW-1:0] rs_q;
  logic [AW:0] rp_q;
  logic [SW-1:0] rel_idx, cfg_idx;
  logic rel_hit, cfg_hit;
  always_comb begin
    rel_hit = 1'b0;
    rel_idx = '0;
    cfg_hit = 1'b0;
    cfg_idx = '0;
    for (int i = 0; i < SLOTS; i++) begin
      if (good_q[i] && tag_q[i] == release_time && !rel_hit) begin
        rel_hit = 1'b1;
        rel_idx = SW'(i);
      end
      if (good_q[i] && tag_q[i] == cfg_time && !cfg_hit) begin
        cfg_hit = 1'b1;
        cfg_idx = SW'(i);
      end
    end
  end

  wire [AW-1:0] rd_a = rp_q[AW-1:0];
  wire [7:0] voted;
  bpp_vote u_vote (
    .copy_a(mem_q[rs_q][0][rd_a]),
    .copy_b(mem_q[rs_q][1][rd_a]),
    .copy_c(mem_q[rs_q][2][rd_a]),
    .n_copies(ncp_q[rs_q]), // R09 R10
    .voted(voted)
  );
  wire rd_end = (rp_q + 1'b1 == blen_q[rs_q]);
  wire start_rel = (tx_q == bpp_pkg::TX_IDLE) && release_go && rel_hit;
  wire start_cfg = (tx_q == bpp_pkg::TX_IDLE) && !release_go && cfg_go && cfg_hit;
  wire free_slot = (tx_q == bpp_pkg::TX_SEND) && rd_end;

  // receive: length, body, check word
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_q <= bpp_pkg::ST_IDLE;
      ws_q <= '0;
      wc_q <= '0;
      len_q <= '0;
      crc_q <= `BPP_CHK_INIT;
      rchk_q <= '0;
      wp_q <= '0;
      hb_q <= '0;
      chk_err <= 1'b0;
    end else begin
      chk_err <= 1'b0;
      case (rx_q)
        bpp_pkg::ST_IDLE: begin
          if (rx_take && in_first) begin
            ws_q <= hit ? hit_idx : free_idx;
            wc_q <= hit ? ((ncp_q[hit_idx] < 2'h3) ? ncp_q[hit_idx] : 2'h2) : 2'h0;
            len_q <= {8'h00, in_data};
            crc_q <= crc_first;
            hb_q <= 2'h1;
            wp_q <= '0;
            rx_q <= (hit || free_ok) ? bpp_pkg::ST_LEN : bpp_pkg::ST_DONE;
          end
        end
        bpp_pkg::ST_LEN: begin
          if (rx_take) begin
            len_q <= {len_q[7:0], in_data};
            crc_q <= crc_n;
            rx_q <= bpp_pkg::ST_BODY;
          end
        end
        bpp_pkg::ST_BODY: begin
          if (rx_take) begin
            crc_q <= crc_n;
            wp_q <= wp_q + 1'b1;
            if (wp_q + 1'b1 == len_q[AW:0] || in_last) begin
              rx_q <= bpp_pkg::ST_CHK;
              hb_q <= '0;
            end
          end
        end
        bpp_pkg::ST_CHK: begin
          if (rx_take) begin
            rchk_q <= chk_word;
            hb_q <= hb_q + 1'b1;
            if (hb_q == 2'(`BPP_CHK_BYTES - 1)) begin
              chk_err <= (chk_word != crc_q); // R05
              rx_q <= bpp_pkg::ST_IDLE;
            end
          end
        end
        bpp_pkg::ST_DONE: rx_q <= bpp_pkg::ST_IDLE;
        default: rx_q <= bpp_pkg::ST_IDLE;
      endcase
    end
  end

  // payload body kept in buffer, header and check word are not stored
  always_ff @(posedge clk) begin
    if (rx_q == bpp_pkg::ST_BODY && rx_take) begin
      mem_q[ws_q][wc_q][wp_q[AW-1:0]] <= in_data; // R01 R07
    end
  end

  // slot bookkeeping
  wire commit = (rx_q == bpp_pkg::ST_CHK) && rx_take && (hb_q == 2'(`BPP_CHK_BYTES - 1));
  wire commit_ok = commit && (chk_word == crc_q);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      used_q <= '0;
      good_q <= '0;
      for (int i = 0; i < SLOTS; i++) begin
        tag_q[i] <= '0;
        ncp_q[i] <= '0;
        blen_q[i] <= '0;
      end
    end else begin
      // a commit in the same cycle as a free wins
      if (free_slot) begin
        used_q[rs_q] <= 1'b0; // R11
        good_q[rs_q] <= 1'b0;
      end
      if (commit_ok) begin
        used_q[ws_q] <= 1'b1;
        good_q[ws_q] <= 1'b1;
        blen_q[ws_q] <= wp_q;
        if (wc_q == 2'h0) begin
          tag_q[ws_q] <= in_time; // R08 R11
        end
        ncp_q[ws_q] <= (copy_count > 2'h1) ? wc_q + 2'h1 : 2'h1; // R09
      end
    end
  end

  // release to inserter or instruction walk
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_q <= bpp_pkg::TX_IDLE;
      rs_q <= '0;
      rp_q <= '0;
      out_valid <= 1'b0;
      out_data <= 8'h00;
      out_last <= 1'b0;
      instr_valid <= 1'b0;
      instr_stage <= 8'h00;
      instr_word <= 32'h0000_0000;
      rel_miss <= 1'b0;
    end else begin
      out_valid <= 1'b0;
      out_last <= 1'b0;
      instr_valid <= 1'b0;
      rel_miss <= 1'b0;
      case (tx_q)
        bpp_pkg::TX_IDLE: begin
          rp_q <= '0;
          rel_miss <= release_go && !rel_hit;
          if (start_rel) begin
            rs_q <= rel_idx;
            tx_q <= bpp_pkg::TX_SEND; // R04
          end else if (start_cfg) begin
            rs_q <= cfg_idx;
            instr_stage <= 8'h00;
            tx_q <= bpp_pkg::TX_CFG; // R03 R06
          end
        end
        bpp_pkg::TX_SEND: begin
          out_valid <= 1'b1;
          out_data <= voted; // R05
          out_last <= rd_end;
          rp_q <= rp_q + 1'b1;
          if (rd_end) begin
            tx_q <= bpp_pkg::TX_IDLE;
          end
        end
        bpp_pkg::TX_CFG: begin
          instr_word <= {instr_word[23:0], voted};
          rp_q <= rp_q + 1'b1;
          if (rp_q[1:0] == 2'(`BPP_INSTR_BYTES - 1) || rd_end) begin
            instr_valid <= 1'b1; // R06
            instr_stage <= instr_stage + 8'h01;
          end
          if (rd_end) begin
            tx_q <= bpp_pkg::TX_IDLE; // R07
          end
        end
        default: tx_q <= bpp_pkg::TX_IDLE;
      endcase
    end
  end
endmodule : bpp_parser

// >>> testbench/bpp_parser_asserts.sv
`timescale 1ns/1ps
module bpp_parser_asserts (
  // watched ports
  input wire logic clk,
  input wire logic rst_n,
  input wire logic release_go,
  input wire logic out_valid,
  input wire logic out_last,
  input wire logic instr_valid,
  input wire logic [7:0] instr_stage,
  input wire logic chk_err,
  input wire logic rel_miss
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_REL_LAT: assert property ($rose(out_valid) |-> $past(release_go, 2)) else $error("late out");
  AST_LAST_IN: assert property (out_last |-> out_valid) else $error("stray last");
  AST_NO_GAP: assert property (out_valid && !out_last |=> out_valid) else $error("gap");
  AST_FREE: assert property (out_valid && out_last |=> !out_valid) else $error("overrun");
  AST_STAGE: assert property (instr_valid |-> instr_stage != 8'h00) else $error("stage 0");
  AST_SPLIT: assert property (!(out_valid && instr_valid)) else $error("overlap");
  AST_ERR_ONE: assert property (chk_err |=> !chk_err) else $error("err wide");
  AST_MISS_ONE: assert property (rel_miss |=> !rel_miss) else $error("miss wide");
endmodule : bpp_parser_asserts
bind bpp_parser bpp_parser_asserts u_chk (.clk, .rst_n, .release_go, .out_valid, .out_last,
  .instr_valid, .instr_stage, .chk_err, .rel_miss);

// >>> testbench/bpp_src.sv
`timescale 1ns/1ps
module bpp_src (
  // control
  input wire logic clk,
  input wire logic start,
  input wire logic [31:0] tag,
  input wire logic [7:0] flip,
  input wire logic bad,
  output logic done,
  // stream
  input wire logic in_ready,
  output logic in_valid,
  output logic [7:0] in_data,
  output logic in_first,
  output logic in_last,
  output logic [31:0] in_time
);
  logic [7:0] pk [8];
  logic [15:0] c;
  initial begin
    {in_valid, in_data, in_first, in_last, in_time, done} = '0;
    forever begin
      @(posedge clk);
      if (start) begin
        pk[0] = 8'h00;
        pk[1] = 8'h04;
        for (int i = 0; i < 4; i++) pk[i+2] = (tag[7:0] + 8'(i)) ^ (i == 0 ? flip : 8'h00);
        c = 16'hFFFF;
        for (int i = 0; i < 48; i++) c = {c[14:0], 1'b0} ^ ((c[15] ^ pk[i/8][7-i%8]) ? 16'h1021 : 16'h0000);
        pk[6] = c[15:8] ^ {7'h00, bad};
        pk[7] = c[7:0];
        for (int i = 0; i < 8; i++) begin
          in_valid <= 1'b1;
          in_data <= pk[i];
          in_first <= i == 0;
          in_last <= i == 7;
          in_time <= tag;
          do @(posedge clk); while (in_ready !== 1'b1);
        end
        in_valid <= 1'b0;
        in_data <= ~in_data;
        done <= 1'b1;
        @(posedge clk);
        done <= 1'b0;
      end
    end
  end
endmodule : bpp_src

// >>> testbench/broadcast_preamble_parser_tb.sv
`timescale 1ns/1ps
module broadcast_preamble_parser_tb;
  typedef struct packed {logic [31:0] tag; logic [7:0] first; logic [31:0] word;} bpp_row_t;
  bpp_row_t rows [3] = '{'{32'h10, 8'h10, 32'h1011_1213}, '{32'h2A, 8'h2A, 32'h2A2B_2C2D},
    '{32'hFF, 8'hFF, 32'hFF00_0102}};
  logic clk, rst_n, in_valid, in_first, in_last, in_ready, cfg_go, release_go, out_valid, out_last;
  logic instr_valid, chk_err, rel_miss, start, bad, done;
  logic [7:0] in_data, out_data, instr_stage, flip;
  logic [31:0] in_time, cfg_time, release_time, instr_word, tag;
  logic [1:0] copy_count;
  int errors, cmp_count, crc_hits;
  bpp_parser dut (.clk, .rst_n, .in_valid, .in_data, .in_first, .in_last, .in_time, .in_ready, .copy_count,
    .cfg_go, .cfg_time, .release_go, .release_time, .out_valid, .out_data, .out_last, .instr_valid,
    .instr_stage, .instr_word, .chk_err, .rel_miss);
  bpp_src u_src (.clk, .start, .tag, .flip, .bad, .done, .in_ready, .in_valid, .in_data, .in_first,
    .in_last, .in_time);
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) if (chk_err === 1'b1) crc_hits++;
  task automatic end_sim;
    $display("errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("BAD %s exp=%0h got=%0h", nm, e, g);
      errors++;
    end
  endtask : chk
  task automatic send(input logic [31:0] t, input logic [7:0] f, input logic b);
    int k;
    @(posedge clk);
    {tag, flip, bad, start} <= {t, f, b, 1'b1};
    @(posedge clk);
    start <= 1'b0;
    for (k = 0; k < 40 && done !== 1'b1; k++) @(posedge clk);
    if (k == 40) begin
      errors++;
      end_sim;
    end
    repeat (4) @(posedge clk);
  endtask : send
  task automatic cfg(input logic [31:0] t, input logic [31:0] w);
    int n;
    n = 0;
    @(posedge clk);
    {cfg_time, cfg_go} <= {t, 1'b1};
    @(posedge clk);
    cfg_go <= 1'b0;
    repeat (20) begin
      @(posedge clk);
      #1;
      if (instr_valid === 1'b1) begin
        chk("instr_stage", 32'h1, 32'(instr_stage));
        chk("instr_word", w, instr_word);
        n++;
      end
    end
    chk("instr_count", 32'h1, n);
  endtask : cfg
  task automatic rel(input logic [31:0] t, input logic [7:0] b, input logic ok);
    int n;
    n = 0;
    @(posedge clk);
    {release_time, release_go} <= {t, 1'b1};
    @(posedge clk);
    release_go <= 1'b0;
    repeat (20) begin
      #1;
      if (rel_miss === 1'b1) n = n + 100;
      if (out_valid === 1'b1) begin
        chk("out_data", 32'(8'(b + 8'(n))), 32'(out_data));
        chk("out_last", 32'(n == 3), 32'(out_last));
        n++;
      end
      @(posedge clk);
    end
    chk("out_bytes", ok ? 32'h4 : 32'h64, n);
  endtask : rel
  initial begin
    {rst_n, cfg_go, release_go, start, bad, cfg_time, release_time, tag, flip} = '0;
    copy_count = 2'h1;
    repeat (8) @(posedge clk);
    chk("rst_out", 32'h0, 32'({out_valid, out_last, instr_valid, chk_err, rel_miss, in_ready}));
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      send(rows[i].tag, 8'h00, 1'b0);
      cfg(rows[i].tag, rows[i].word);
      rel(rows[i].tag, rows[i].first, 1'b1);
    end
    rel(rows[0].tag, 8'h00, 1'b0);
    send(32'h31, 8'h00, 1'b0);
    send(32'h42, 8'h00, 1'b0);
    rel(32'h42, 8'h42, 1'b1);
    rel(32'h31, 8'h31, 1'b1);
    chk("crc_ok", 32'h0, crc_hits);
    send(32'h55, 8'h00, 1'b1);
    chk("crc_bad", 32'h1, crc_hits);
    rel(32'h55, 8'h00, 1'b0);
    copy_count <= 2'h3;
    send(32'h77, 8'h08, 1'b0);
    send(32'h77, 8'h00, 1'b0);
    send(32'h77, 8'h00, 1'b0);
    rel(32'h77, 8'h77, 1'b1);
    for (int i = 0; i < 5; i++) send(32'h61 + i, 8'h00, 1'b0);
    rel(32'h65, 8'h00, 1'b0);
    for (int i = 0; i < 4; i++) rel(32'h61 + i, 8'(8'h61 + i), 1'b1);
    send(32'h88, 8'h00, 1'b0);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk("mid_rst_out", 32'h0, 32'({out_valid, out_last, instr_valid, chk_err, rel_miss, in_ready}));
    rst_n <= 1'b1;
    rel(32'h88, 8'h00, 1'b0);
    end_sim;
  end
endmodule : broadcast_preamble_parser_tb
